// file: logic/olpg_defines.svh
`ifndef OLPG_DEFINES_SVH
`define OLPG_DEFINES_SVH

// register byte offsets on the bus
`define OLPG_REG_CMD 12'h000
`define OLPG_REG_ADDR 12'h004
`define OLPG_REG_WDATA 12'h008
`define OLPG_REG_RDATA 12'h00C
`define OLPG_REG_FSR 12'h010
`define OLPG_REG_CFG 12'h014
`define OLPG_REG_STAT 12'h018

// field positions, reset values and erased byte value
`define OLPG_FSR_WREN_BIT 1
`define OLPG_CFG_QUAD_BIT 1
`define OLPG_FSR_RESET 8'h00
`define OLPG_CFG_RESET 8'h00
`define OLPG_ERASED 8'hFF

// command opcodes
`define OLPG_OP_WREN 8'h06
`define OLPG_OP_WRDI 8'h04
`define OLPG_OP_RDSTAT 8'h05
`define OLPG_OP_PGPROG 8'h02
`define OLPG_OP_OTPP 8'h42
`define OLPG_OP_OTPR 8'h4B
`define OLPG_OP_DPD 8'hB9
`define OLPG_OP_RES 8'hAB

// one-time-programmable map
`define OLPG_OTP_BASE 10'h100
`define OLPG_OTP_TOP 10'h2FF
`define OLPG_OTP_RSVD 10'h101
`define OLPG_LOCK_ESN 10'h100
`define OLPG_ESN_A_LO 10'h102
`define OLPG_ESN_A_HI 10'h109
`define OLPG_ESN_B_LO 10'h10A
`define OLPG_ESN_B_HI 10'h111
`define OLPG_LOCK_UP_LO 10'h214
`define OLPG_LOCK_UP_HI 10'h215
`define OLPG_UP_REGION_BASE 10'h216
`define OLPG_MASK_ESN 8'h03
`define OLPG_MASK_UP_HI 8'h7F
`define OLPG_MASK_ALL 8'hFF

// timing
`define OLPG_CLK_MHZ 250
`define OLPG_PU_DELAY_US 300
`define OLPG_ACC_SETTLE_US 5
`define OLPG_PU_CYCLES (`OLPG_PU_DELAY_US * `OLPG_CLK_MHZ)
`define OLPG_SETTLE_CYCLES (`OLPG_ACC_SETTLE_US * `OLPG_CLK_MHZ)

`endif

// file: logic/olpg_pkg.sv
package olpg_pkg;

   typedef enum logic [1:0] {
      PW_OFF,
      PW_WAIT,
      PW_READY
   } olpg_power_t;

endpackage : olpg_pkg

// file: logic/olpg_sync.sv
`timescale 1ns/1ns
module olpg_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // a change counts once stages two and three agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            s1_q[i] <= 1'b0;
            s2_q[i] <= 1'b0;
            s3_q[i] <= 1'b0;
            dout[i] <= 1'b0;
         end else begin
            s1_q[i] <= din[i];
            s2_q[i] <= s1_q[i];
            s3_q[i] <= s2_q[i];
            if (s2_q[i] == s3_q[i]) begin
               dout[i] <= s3_q[i];
            end
         end
      end
   end
endmodule : olpg_sync

// file: logic/olpg_lock_eval.sv
`timescale 1ns/1ns
`include "olpg_defines.svh"
module olpg_lock_eval (
   input wire logic [9:0] addr,
   input wire logic [7:0] lock_esn,
   input wire logic [7:0] lock_up_lo,
   input wire logic [7:0] lock_up_hi,
   output logic in_range,
   output logic locked,
   output logic [7:0] prog_mask
);
   logic [9:0] up_off;
   logic [3:0] up_idx;
   logic [14:0] up_bits;

   assign up_off = addr - `OLPG_UP_REGION_BASE;
   assign up_idx = up_off[7:4];
   assign up_bits = {lock_up_hi[6:0], lock_up_lo};

   always_comb begin
      in_range = (addr >= `OLPG_OTP_BASE) && (addr <= `OLPG_OTP_TOP) &&
                 (addr != `OLPG_OTP_RSVD);
      prog_mask = `OLPG_MASK_ALL;
      if (addr == `OLPG_LOCK_ESN) begin
         prog_mask = `OLPG_MASK_ESN;
      end else if (addr == `OLPG_LOCK_UP_HI) begin
         prog_mask = `OLPG_MASK_UP_HI;
      end
      locked = 1'b0;
      if (addr >= `OLPG_ESN_A_LO && addr <= `OLPG_ESN_A_HI) begin
         locked = ~lock_esn[0];
      end else if (addr >= `OLPG_ESN_B_LO && addr <= `OLPG_ESN_B_HI) begin
         locked = ~lock_esn[1];
      end else if (addr >= `OLPG_UP_REGION_BASE &&
                   addr <= `OLPG_OTP_TOP) begin
         locked = ~up_bits[up_idx];
      end
   end
endmodule : olpg_lock_eval

// file: logic/olpg_top.sv
`timescale 1ns/1ns
`include "olpg_defines.svh"
module olpg_top
   import olpg_pkg::*;
#(
   parameter int PU_CYCLES = `OLPG_PU_CYCLES
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic power_good,
   input wire logic accel_high_voltage,
   output logic device_ready
);

   localparam int PU_W = $clog2(PU_CYCLES + 1);
   localparam int SETTLE = `OLPG_SETTLE_CYCLES;
   localparam int SET_W = $clog2(SETTLE + 1);
   localparam int OTP_BYTES = 512;

   if (PU_CYCLES < 1) begin : g_chk
      $error("PU_CYCLES must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers

   logic pg_s;
   logic hv_s;

   olpg_sync #(
      .W(2)
   ) u_sync (
      .clk(pclk),
      .rst_n(presetn),
      .din({power_good, accel_high_voltage}),
      .dout({pg_s, hv_s})
   );

   ////////////////////////////////////////////////////////////////////////
   // state

   olpg_power_t pw_q;
   logic [PU_W-1:0] pu_cnt_q;
   logic [SET_W-1:0] settle_q;
   logic accel_on_q;
   logic dpd_q;
   logic wr_en_q;
   logic [7:0] cfg_q;
   logic [7:0] cmd_q;
   logic [9:0] addr_q;
   logic [7:0] wdata_q;
   logic [7:0] rdata_q;
   logic ignored_q;
   logic blocked_q;
   logic [7:0] otp_q [OTP_BYTES];

   ////////////////////////////////////////////////////////////////////////
   // bus decode

   logic xfer;
   logic wr_go;
   logic mapped;

   assign xfer = psel && penable && pready;
   assign wr_go = xfer && pwrite;

   always_comb begin
      unique case (paddr)
         `OLPG_REG_CMD, `OLPG_REG_ADDR, `OLPG_REG_WDATA, `OLPG_REG_RDATA,
         `OLPG_REG_FSR, `OLPG_REG_CFG, `OLPG_REG_STAT: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // command gating

   logic [7:0] op;
   logic cmd_go;
   logic known;
   logic gate_ok;
   logic accepted;
   logic accel_eff;
   logic quad;

   assign op = pwdata[7:0];
   assign cmd_go = wr_go && (paddr == `OLPG_REG_CMD);
   assign quad = cfg_q[`OLPG_CFG_QUAD_BIT];
   assign accel_eff = hv_s && !quad;

   always_comb begin
      unique case (op)
         `OLPG_OP_WREN, `OLPG_OP_WRDI, `OLPG_OP_RDSTAT, `OLPG_OP_PGPROG,
         `OLPG_OP_OTPP, `OLPG_OP_OTPR, `OLPG_OP_DPD,
         `OLPG_OP_RES: known = 1'b1;
         default: known = 1'b0;
      endcase
      gate_ok = known;
      if (pw_q != PW_READY) begin
         gate_ok = 1'b0;
      end
      if (settle_q != '0) begin
         gate_ok = 1'b0;
      end
      if (dpd_q && op != `OLPG_OP_RES) begin
         gate_ok = 1'b0;
      end
      if (accel_on_q && op != `OLPG_OP_RDSTAT && op != `OLPG_OP_PGPROG) begin
         gate_ok = 1'b0;
      end
   end

   assign accepted = cmd_go && gate_ok;

   ////////////////////////////////////////////////////////////////////////
   // lock evaluation

   logic in_range;
   logic locked;
   logic [7:0] prog_mask;
   logic [8:0] idx;
   logic prog_ok;
   logic otpp_go;

   assign idx = addr_q[8:0] ^ 9'h100;

   olpg_lock_eval u_lock (
      .addr(addr_q),
      .lock_esn(otp_q[9'h000]),
      .lock_up_lo(otp_q[9'h114]),
      .lock_up_hi(otp_q[9'h115]),
      .in_range(in_range),
      .locked(locked),
      .prog_mask(prog_mask)
   );

   assign otpp_go = accepted && (op == `OLPG_OP_OTPP) && wr_en_q;
   assign prog_ok = otpp_go && in_range && !locked;

   ////////////////////////////////////////////////////////////////////////
   // power sequencing

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pw_q <= PW_OFF;
         pu_cnt_q <= '0;
      end else begin
         unique case (pw_q)
            PW_OFF: begin
               pu_cnt_q <= '0;
               if (pg_s) begin
                  pw_q <= PW_WAIT;
               end
            end
            PW_WAIT: begin
               if (!pg_s) begin
                  pw_q <= PW_OFF;
               end else if (pu_cnt_q == PU_W'(PU_CYCLES - 1)) begin
                  pw_q <= PW_READY;
               end else begin
                  pu_cnt_q <= pu_cnt_q + 1'b1;
               end
            end
            PW_READY: begin
               if (!pg_s) begin
                  pw_q <= PW_OFF;
               end
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         device_ready <= 1'b0;
      end else begin
         device_ready <= (pw_q == PW_READY) && !dpd_q && (settle_q == '0);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // acceleration settle

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         accel_on_q <= 1'b0;
         settle_q <= '0;
      end else if (accel_eff != accel_on_q) begin
         accel_on_q <= accel_eff;
         settle_q <= SET_W'(SETTLE);
      end else if (settle_q != '0) begin
         settle_q <= settle_q - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write enable latch and deep power-down

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_en_q <= 1'b0;
      end else if (pw_q != PW_READY) begin
         wr_en_q <= 1'b0;
      end else if (accepted) begin
         unique case (op)
            `OLPG_OP_WREN: wr_en_q <= 1'b1;
            `OLPG_OP_WRDI, `OLPG_OP_PGPROG, `OLPG_OP_OTPP: wr_en_q <= 1'b0;
            default: wr_en_q <= wr_en_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dpd_q <= 1'b0;
      end else if (pw_q != PW_READY) begin
         dpd_q <= 1'b0;
      end else if (accepted && op == `OLPG_OP_DPD) begin
         dpd_q <= 1'b1;
      end else if (accepted && op == `OLPG_OP_RES) begin
         dpd_q <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software-written registers, command status flags and read result

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_q <= `OLPG_CFG_RESET;
         addr_q <= '0;
         wdata_q <= '0;
         cmd_q <= '0;
      end else if (wr_go) begin
         unique case (paddr)
            `OLPG_REG_CFG: cfg_q <= pwdata[7:0];
            `OLPG_REG_ADDR: addr_q <= pwdata[9:0];
            `OLPG_REG_WDATA: wdata_q <= pwdata[7:0];
            `OLPG_REG_CMD: cmd_q <= op;
            default: cmd_q <= cmd_q;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ignored_q <= 1'b0;
         blocked_q <= 1'b0;
      end else if (cmd_go) begin
         ignored_q <= !gate_ok;
         blocked_q <= otpp_go && !prog_ok;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= '0;
      end else if (accepted && op == `OLPG_OP_RDSTAT) begin
         rdata_q <= {6'h0, wr_en_q, 1'b0};
      end else if (accepted && op == `OLPG_OP_OTPR) begin
         rdata_q <= otp_q[idx];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one-time-programmable storage, programming only moves bits from one to zero, reset reloads all ones

   for (genvar i = 0; i < OTP_BYTES; i++) begin : g_otp
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            otp_q[i] <= `OLPG_ERASED;
         end else if (prog_ok && idx == 9'(i)) begin
            otp_q[i] <= otp_q[i] & (wdata_q | ~prog_mask);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus answer: one wait state, then pready

   logic [31:0] rd_mux;

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         `OLPG_REG_CMD: rd_mux[7:0] = cmd_q;
         `OLPG_REG_ADDR: rd_mux[9:0] = addr_q;
         `OLPG_REG_WDATA: rd_mux[7:0] = wdata_q;
         `OLPG_REG_RDATA: rd_mux[7:0] = rdata_q;
         `OLPG_REG_FSR: rd_mux[`OLPG_FSR_WREN_BIT] = wr_en_q;
         `OLPG_REG_CFG: rd_mux[7:0] = cfg_q;
         `OLPG_REG_STAT: rd_mux[7:0] = {blocked_q, ignored_q, settle_q != '0,
                                        accel_on_q, dpd_q, wr_en_q, pw_q};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end
   end

endmodule : olpg_top

// file: dv/olpg_chk.sv
`timescale 1ns/1ns
module olpg_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic power_good,
   input wire logic accel_high_voltage,
   input wire logic device_ready
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   property p_rdy_pulse;
      pready |=> !pready;
   endproperty
   a_rdy_pulse: assert property (p_rdy_pulse)
      else $error("pready held past one cycle");
   property p_rdy_cause;
      pready |-> psel && penable;
   endproperty
   a_rdy_cause: assert property (p_rdy_cause)
      else $error("pready outside an access phase");
   property p_rdy_lat;
      $rose(psel && penable) |=> pready;
   endproperty
   a_rdy_lat: assert property (p_rdy_lat)
      else $error("pready not in second access cycle");
   property p_err_pair;
      pslverr |-> pready;
   endproperty
   a_err_pair: assert property (p_err_pair)
      else $error("pslverr without pready");
   property p_err_map;
      pready |-> pslverr == (paddr > 12'h018 || paddr[1:0] != 2'b00);
   endproperty
   a_err_map: assert property (p_err_map)
      else $error("pslverr does not match address map");
   property p_rd_zero;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_rd_zero: assert property (p_rd_zero)
      else $error("prdata not zero outside pready");
   property p_upper;
      pready && !pwrite |-> prdata[31:10] == 22'h00_0000 &&
         (paddr == 12'h004 || prdata[9:8] == 2'b00);
   endproperty
   a_upper: assert property (p_upper)
      else $error("read data upper bits set");
   property p_pg_off;
      !power_good [*8] |-> !device_ready;
   endproperty
   a_pg_off: assert property (p_pg_off)
      else $error("ready while supply is lost");
   property p_rdy_gate;
      $rose(device_ready) |-> power_good && $past(power_good);
   endproperty
   a_rdy_gate: assert property (p_rdy_gate)
      else $error("ready rose without supply");
endmodule : olpg_chk

bind olpg_top olpg_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .power_good(power_good), .accel_high_voltage(accel_high_voltage),
   .device_ready(device_ready));

// file: dv/olpg_host_pwr.sv
`timescale 1ns/1ns
module olpg_host_pwr #(
   parameter int RAMP = 6
) (
   input wire logic pclk,
   input wire logic pwr_on,
   input wire logic acc_on,
   output logic power_good = 1'b0,
   output logic accel_high_voltage = 1'b0
);
   int ramp_q = 0;
   // supply ramps before good, drops at once
   always @(posedge pclk) begin
      if (!pwr_on) begin
         power_good <= 1'b0;
         ramp_q <= 0;
      end else if (ramp_q == RAMP) begin
         power_good <= 1'b1;
      end else begin
         ramp_q <= ramp_q + 1;
      end
      accel_high_voltage <= acc_on && power_good;
   end
endmodule : olpg_host_pwr

// file: dv/otp_lock_and_power_gating_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module otp_lock_and_power_gating_tb_top;
   localparam int PU = 20;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdv;
   logic power_good, accel_high_voltage, device_ready, erv;
   logic pwr_on = 1'b0;
   logic acc_on = 1'b0;
   int errors = 0;
   int cmp_count = 0;
   int tick = 0;
   int wcnt;
   olpg_top #(.PU_CYCLES(PU)) u_olpg_top (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .power_good(power_good), .accel_high_voltage(accel_high_voltage),
      .device_ready(device_ready));
   olpg_host_pwr u_olpg_host_pwr (.pclk(pclk), .pwr_on(pwr_on),
      .acc_on(acc_on), .power_good(power_good),
      .accel_high_voltage(accel_high_voltage));
   ////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [9:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {22'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdv = prdata;
      erv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic prog(input logic [9:0] a, input logic [7:0] d);
      apb(1, 12'h004, a);
      apb(1, 12'h008, {2'b00, d});
      apb(1, 12'h000, 10'h006);
      apb(1, 12'h000, 10'h042);
   endtask : prog
   task automatic otp(input logic [9:0] a);
      apb(1, 12'h004, a);
      apb(1, 12'h000, 10'h04B);
      apb(0, 12'h00C, 10'h000);
   endtask : otp
   task automatic wait_rdy;
      wcnt = 0;
      while (device_ready !== 1'b1) begin
         @(posedge pclk);
         wcnt++;
      end
   endtask : wait_rdy
   ////////////////////////////////////////////////////////////////////////
   task automatic t_off;
      apb(1, 12'h000, 10'h006);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[6], 1'b1)
      apb(0, 12'h010, 10'h000);
      `CHK(rdv[7:0], 8'h00)
      apb(0, 12'h014, 10'h000);
      `CHK(rdv[7:0], 8'h00)
      apb(0, 12'h01C, 10'h000);
      `CHK(erv, 1'b1)
   endtask : t_off
   task automatic t_power;
      pwr_on <= 1'b1;
      wait_rdy;
      `CHK(wcnt >= PU, 1'b1)
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[3:0], 4'h2)
      otp(10'h150);
      `CHK(rdv[7:0], 8'hFF)
      apb(1, 12'h000, 10'h0B9);
      apb(1, 12'h000, 10'h006);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[7:0], 8'h4A)
      `CHK(device_ready, 1'b0)
      apb(1, 12'h000, 10'h0AB);
      apb(1, 12'h000, 10'h006);
      apb(1, 12'h000, 10'h004);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[7:0], 8'h02)
   endtask : t_power
   task automatic t_esn;
      prog(10'h105, 8'h5A);
      prog(10'h105, 8'hF0);
      otp(10'h105);
      `CHK(rdv[7:0], 8'h50)
      prog(10'h100, 8'h00);
      otp(10'h100);
      `CHK(rdv[7:0], 8'hFC)
      prog(10'h102, 8'h00);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[7], 1'b1)
      otp(10'h102);
      `CHK(rdv[7:0], 8'hFF)
      prog(10'h111, 8'h00);
      otp(10'h111);
      `CHK(rdv[7:0], 8'hFF)
   endtask : t_esn
   task automatic t_upper;
      prog(10'h214, 8'hFE);
      prog(10'h215, 8'h00);
      otp(10'h215);
      `CHK(rdv[7:0], 8'h80)
      prog(10'h216, 8'h00);
      otp(10'h216);
      `CHK(rdv[7:0], 8'hFF)
      prog(10'h226, 8'h00);
      otp(10'h226);
      `CHK(rdv[7:0], 8'h00)
      prog(10'h2FF, 8'h00);
      otp(10'h2FF);
      `CHK(rdv[7:0], 8'hFF)
   endtask : t_upper
   task automatic t_range;
      prog(10'h101, 8'h00);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[7], 1'b1)
      prog(10'h0FF, 8'h00);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[7], 1'b1)
      apb(1, 12'h004, 10'h130);
      apb(1, 12'h000, 10'h042);
      otp(10'h130);
      `CHK(rdv[7:0], 8'hFF)
   endtask : t_range
   task automatic t_accel;
      acc_on <= 1'b1;
      repeat (8) @(posedge pclk);
      `CHK(device_ready, 1'b0)
      wait_rdy;
      apb(1, 12'h000, 10'h006);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[6], 1'b1)
      apb(1, 12'h000, 10'h005);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[6], 1'b0)
      apb(1, 12'h000, 10'h002);
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[6], 1'b0)
      apb(1, 12'h014, 10'h002);
      repeat (8) @(posedge pclk);
      wait_rdy;
      apb(1, 12'h000, 10'h006);
      apb(0, 12'h010, 10'h000);
      `CHK(rdv[1], 1'b1)
      apb(1, 12'h014, 10'h000);
      acc_on <= 1'b0;
      repeat (8) @(posedge pclk);
      wait_rdy;
   endtask : t_accel
   task automatic t_loss;
      apb(1, 12'h000, 10'h006);
      pwr_on <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1, 12'h000, 10'h006);
      apb(0, 12'h010, 10'h000);
      `CHK(rdv[1], 1'b0)
      apb(0, 12'h018, 10'h000);
      `CHK(rdv[6], 1'b1)
   endtask : t_loss
   ////////////////////////////////////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      tick++;
      if (tick == 30000) begin
         errors++;
         test_done;
      end
   end
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_off;
      t_power;
      t_esn;
      t_upper;
      t_range;
      t_accel;
      t_loss;
      test_done;
   end
endmodule : otp_lock_and_power_gating_tb_top
